// >>> src/mpgsp_pkg.sv
// Constants, register map and types shared by the port block
package mpgsp_pkg;

	// ---------------------------------------------------------------
	// Port geometry
	// ---------------------------------------------------------------
	localparam int NPORT = 7;
	localparam int NPIN_RAW = 28;
	localparam logic [6:0] BIDIR_PORTS = 7'h79;
	localparam logic [6:0] OD_PORTS = 7'h30;
	localparam logic [6:0] GROUP_PU_PORTS = 7'h30;
	localparam logic [6:0] ALT_PORTS = 7'h49;
	localparam logic [3:0] WIDTH_MASK [NPORT] = '{4'h7, 4'h3, 4'hF, 4'h7, 4'hF, 4'hF, 4'hF};

	// ---------------------------------------------------------------
	// Register map (byte addresses, haddr[7:0])
	// ---------------------------------------------------------------
	localparam logic [3:0] OFS_DATA = 4'h0;
	localparam logic [3:0] OFS_DIR = 4'h4;
	localparam logic [3:0] OFS_PULLUP = 4'h8;
	localparam logic [3:0] OFS_MODE = 4'hC;
	localparam logic [7:0] ADDR_P45_DATA = 8'h70;
	localparam logic [7:0] ADDR_BITOP = 8'h74;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h80;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h84;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h88;
	localparam logic [7:0] ADDR_CONFIG = 8'h8C;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int BITOP_PIN_LSB = 0;
	localparam int BITOP_PORT_LSB = 4;
	localparam int BITOP_VAL_BIT = 8;
	localparam int NIRQ = 5;
	localparam int IRQ_EXT_BOTH = 0;
	localparam int IRQ_EXT_SEL = 1;
	localparam int IRQ_QUASI_LSB = 2;
	localparam int CFG_EDGE_FALL_BIT = 0;
	localparam int CFG_CMP_EXTREF_BIT = 1;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] RST_NIBBLE = 4'h0;
	localparam logic [NIRQ-1:0] RST_IRQ = 5'h00;
	localparam logic [1:0] RST_CFG = 2'h0;
	localparam logic [3:0] CMP_ALL_CH = 4'hF;
	localparam logic [3:0] CMP_THREE_CH = 4'h7;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_RDWAIT = 2'b10
	} mpgsp_bus_t;

endpackage

// >>> src/mpgsp_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module mpgsp_sync #(
	parameter int W = 28
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// >>> src/mpgsp_edge.sv
// Per-bit rise and fall detector on synchronised levels
`timescale 1ns/1ps
`default_nettype none
module mpgsp_edge #(
	parameter int W = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] prev_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= level;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign rise[i] = level[i] & ~prev_reg[i];
			assign fall[i] = ~level[i] & prev_reg[i];
		end
	endgenerate
endmodule
`default_nettype wire

// >>> src/mpgsp_top.sv
// Seven-port GPIO block with shared pins, edge interrupts and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Ports 0 and 3: three pins, per-pin direction, bit or group access.
// - Pull-ups on bidirectional inputs, forced off while a pin drives.
// - Port 1: two input pins, bit or group read, software pull-ups.
// - Port 2: four input pins, bit or group read.
// - Ports 4 and 5: four pins each, per-pin direction, 1/4/8-bit access.
// - Ports 4 and 5 pull-ups set per nibble, off on output pins.
// - Port 6: four bidirectional pins, per-pin direction, pull-ups, bit or group access.
// - First external interrupt flags on both edges.
// - Second external interrupt flags on one configured edge.
// - Comparator pins 0-2 inputs only; pin 3 input or reference.
// - External reference mode compares three channels, pin 3 carries reference.
// - Three quasi-interrupt pins of port 6 flag falling edges.
module mpgsp_top
	import mpgsp_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [2:0] p0_in,
	output logic [2:0] p0_out,
	output logic [2:0] p0_oe_n,
	output logic [2:0] p0_pu,
	input wire logic [1:0] p1_in,
	output logic [1:0] p1_pu,
	input wire logic [3:0] p2_in,
	input wire logic [2:0] p3_in,
	output logic [2:0] p3_out,
	output logic [2:0] p3_oe_n,
	output logic [2:0] p3_pu,
	input wire logic [3:0] p4_in,
	output logic [3:0] p4_out,
	output logic [3:0] p4_oe_n,
	output logic [3:0] p4_pu,
	input wire logic [3:0] p5_in,
	output logic [3:0] p5_out,
	output logic [3:0] p5_oe_n,
	output logic [3:0] p5_pu,
	input wire logic [3:0] p6_in,
	output logic [3:0] p6_out,
	output logic [3:0] p6_oe_n,
	output logic [3:0] p6_pu,
	input wire logic [2:0] alt_p0_out,
	input wire logic [2:0] alt_p0_dir,
	input wire logic [2:0] alt_p3_out,
	input wire logic [2:0] alt_p3_dir,
	input wire logic [3:0] alt_p6_out,
	input wire logic [3:0] alt_p6_dir,
	output logic [3:0] cmp_channel_en,
	output logic cmp_ext_ref_sel,
	output logic irq
);
	import mpgsp_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ---------------------------------------------------------------
	logic [NPIN_RAW-1:0] pin_raw;
	logic [NPIN_RAW-1:0] pin_sync;
	logic [3:0] pin_s [NPORT];
	logic [3:0] p1_rise;
	logic [3:0] p1_fall;
	logic [3:0] p6_rise;
	logic [3:0] p6_fall;

	assign pin_raw = {p6_in, p5_in, p4_in, 1'b0, p3_in, p2_in, 2'b00, p1_in, 1'b0, p0_in};

	mpgsp_sync #(.W(NPIN_RAW)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(pin_raw),
		.sync_out(pin_sync)
	);

	genvar gp;
	generate
		for (gp = 0; gp < NPORT; gp++) begin : g_pin
			assign pin_s[gp] = pin_sync[4*gp +: 4] & WIDTH_MASK[gp];
		end
	endgenerate

	mpgsp_edge #(.W(4)) u_edge_p1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.level(pin_s[1]),
		.rise(p1_rise),
		.fall(p1_fall)
	);

	mpgsp_edge #(.W(4)) u_edge_p6 (
		.hclk(hclk),
		.hresetn(hresetn),
		.level(pin_s[6]),
		.rise(),
		.fall(p6_fall)
	);
	assign p6_rise = 4'h0;

	// ---------------------------------------------------------------
	// AHB-Lite slave: writes take no wait, reads take one
	// ---------------------------------------------------------------
	mpgsp_bus_t bus_reg;
	logic [7:0] addr_reg;
	logic wr_reg;
	logic acc;
	logic [31:0] rd_mux;

	assign acc = hsel & hready & htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_reg <= BUS_IDLE;
			addr_reg <= 8'h00;
			wr_reg <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
		end else begin
			case (bus_reg)
				BUS_IDLE: begin
					wr_reg <= acc & hwrite;
					if (acc) begin
						addr_reg <= haddr[7:0];
					end
					if (acc && !hwrite) begin
						bus_reg <= BUS_RDWAIT;
						hreadyout <= 1'b0;
					end
				end
				BUS_RDWAIT: begin
					// Sampled here so a write just before the read is seen
					hrdata <= rd_mux;
					hreadyout <= 1'b1;
					bus_reg <= BUS_IDLE;
				end
				default: begin
					bus_reg <= BUS_IDLE;
					hreadyout <= 1'b1;
					wr_reg <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Port registers
	// ---------------------------------------------------------------
	logic [3:0] dat_reg [NPORT];
	logic [3:0] dir_reg [NPORT];
	logic [3:0] pu_reg [NPORT];
	logic [3:0] mode_reg [NPORT];
	logic [NIRQ-1:0] status_reg;
	logic [NIRQ-1:0] irq_en_reg;
	logic [1:0] cfg_reg;
	logic bitop_wr;
	logic p45_wr;
	logic [2:0] bitop_port;
	logic [1:0] bitop_pin;

	assign bitop_wr = wr_reg && (addr_reg == ADDR_BITOP);
	assign p45_wr = wr_reg && (addr_reg == ADDR_P45_DATA);
	assign bitop_port = hwdata[BITOP_PORT_LSB +: 3];
	assign bitop_pin = hwdata[BITOP_PIN_LSB +: 2];

	generate
		for (gp = 0; gp < NPORT; gp++) begin : g_regs
			logic sel;
			logic [3:0] keep;
			assign sel = wr_reg && (addr_reg[7:4] == 4'(gp));
			// Input-only ports keep no direction, latch or mode state
			assign keep = BIDIR_PORTS[gp] ? WIDTH_MASK[gp] : 4'h0;

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					dat_reg[gp] <= RST_NIBBLE;
				end else if (sel && addr_reg[3:0] == OFS_DATA) begin
					dat_reg[gp] <= hwdata[3:0] & keep;
				end else if (p45_wr && (gp == 4 || gp == 5)) begin
					dat_reg[gp] <= hwdata[4*(gp%2) +: 4];
				end else if (bitop_wr && bitop_port == 3'(gp) && keep[bitop_pin]) begin
					dat_reg[gp][bitop_pin] <= hwdata[BITOP_VAL_BIT];
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					dir_reg[gp] <= RST_NIBBLE;
				end else if (sel && addr_reg[3:0] == OFS_DIR) begin
					dir_reg[gp] <= hwdata[3:0] & keep;
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pu_reg[gp] <= RST_NIBBLE;
				end else if (sel && addr_reg[3:0] == OFS_PULLUP) begin
					if (GROUP_PU_PORTS[gp]) begin
						pu_reg[gp] <= {3'b000, hwdata[0]};
					end else begin
						pu_reg[gp] <= hwdata[3:0] & WIDTH_MASK[gp];
					end
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					mode_reg[gp] <= RST_NIBBLE;
				end else if (sel && addr_reg[3:0] == OFS_MODE) begin
					mode_reg[gp] <= hwdata[3:0] & ((OD_PORTS[gp] | ALT_PORTS[gp]) ? keep : 4'h0);
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Pin drive, open-drain and pull-up control
	// ---------------------------------------------------------------
	logic [3:0] alt_out_a [NPORT];
	logic [3:0] alt_dir_a [NPORT];
	logic [3:0] pad_out_reg [NPORT];
	logic [3:0] pad_oe_n_reg [NPORT];
	logic [3:0] pad_pu_reg [NPORT];

	assign alt_out_a = '{{1'b0, alt_p0_out}, 4'h0, 4'h0, {1'b0, alt_p3_out}, 4'h0, 4'h0, alt_p6_out};
	assign alt_dir_a = '{{1'b0, alt_p0_dir}, 4'h0, 4'h0, {1'b0, alt_p3_dir}, 4'h0, 4'h0, alt_p6_dir};

	generate
		for (gp = 0; gp < NPORT; gp++) begin : g_pad
			logic [3:0] alt_en;
			logic [3:0] od_en;
			logic [3:0] drive;
			logic [3:0] value;
			logic [3:0] pu_req;
			assign alt_en = ALT_PORTS[gp] ? mode_reg[gp] : 4'h0;
			assign od_en = OD_PORTS[gp] ? mode_reg[gp] : 4'h0;
			// A shared function takes over direction and value
			assign drive = ((alt_en & alt_dir_a[gp]) | (~alt_en & dir_reg[gp])) & WIDTH_MASK[gp];
			assign value = (alt_en & alt_out_a[gp]) | (~alt_en & dat_reg[gp]);
			assign pu_req = GROUP_PU_PORTS[gp] ? {4{pu_reg[gp][0]}} : pu_reg[gp];

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pad_out_reg[gp] <= RST_NIBBLE;
					pad_oe_n_reg[gp] <= 4'hF;
					pad_pu_reg[gp] <= RST_NIBBLE;
				end else begin
					pad_out_reg[gp] <= value & WIDTH_MASK[gp];
					// Open-drain pins only sink; a high leaves the pin released
					pad_oe_n_reg[gp] <= ~(drive & (~od_en | ~value));
					pad_pu_reg[gp] <= pu_req & WIDTH_MASK[gp] & ~drive;
				end
			end
		end
	endgenerate

	assign p0_out = pad_out_reg[0][2:0];
	assign p0_oe_n = pad_oe_n_reg[0][2:0];
	assign p0_pu = pad_pu_reg[0][2:0];
	assign p1_pu = pad_pu_reg[1][1:0];
	assign p3_out = pad_out_reg[3][2:0];
	assign p3_oe_n = pad_oe_n_reg[3][2:0];
	assign p3_pu = pad_pu_reg[3][2:0];
	assign p4_out = pad_out_reg[4];
	assign p4_oe_n = pad_oe_n_reg[4];
	assign p4_pu = pad_pu_reg[4];
	assign p5_out = pad_out_reg[5];
	assign p5_oe_n = pad_oe_n_reg[5];
	assign p5_pu = pad_pu_reg[5];
	assign p6_out = pad_out_reg[6];
	assign p6_oe_n = pad_oe_n_reg[6];
	assign p6_pu = pad_pu_reg[6];

	// ---------------------------------------------------------------
	// Interrupt status, enable, clear and configuration
	// ---------------------------------------------------------------
	logic [NIRQ-1:0] irq_ev;
	logic [NIRQ-1:0] irq_clr;
	logic [NIRQ-1:0] status_next;

	assign irq_ev[IRQ_EXT_BOTH] = p1_rise[0] | p1_fall[0];
	assign irq_ev[IRQ_EXT_SEL] = cfg_reg[CFG_EDGE_FALL_BIT] ? p1_fall[1] : p1_rise[1];
	assign irq_ev[IRQ_QUASI_LSB +: 3] = p6_fall[2:0] | p6_rise[2:0];
	assign irq_clr = (wr_reg && addr_reg == ADDR_IRQ_CLEAR) ? hwdata[NIRQ-1:0] : '0;
	// New events win over a clear in the same cycle
	assign status_next = (status_reg & ~irq_clr) | irq_ev;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= RST_IRQ;
			irq <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq <= |(status_next & irq_en_reg);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_en_reg <= RST_IRQ;
			cfg_reg <= RST_CFG;
		end else if (wr_reg && addr_reg == ADDR_IRQ_ENABLE) begin
			irq_en_reg <= hwdata[NIRQ-1:0];
		end else if (wr_reg && addr_reg == ADDR_CONFIG) begin
			cfg_reg <= hwdata[1:0];
		end
	end

	// Comparator channel selection; pin 3 is the reference in external mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_channel_en <= CMP_ALL_CH;
			cmp_ext_ref_sel <= 1'b0;
		end else begin
			cmp_channel_en <= cfg_reg[CFG_CMP_EXTREF_BIT] ? CMP_THREE_CH : CMP_ALL_CH;
			cmp_ext_ref_sel <= cfg_reg[CFG_CMP_EXTREF_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Read multiplexer
	// ---------------------------------------------------------------
	always_comb begin
		rd_mux = 32'h00000000;
		if (addr_reg[7:4] < 4'(NPORT)) begin
			case (addr_reg[3:0])
				OFS_DATA: rd_mux[3:0] = pin_s[addr_reg[6:4]];
				OFS_DIR: rd_mux[3:0] = dir_reg[addr_reg[6:4]];
				OFS_PULLUP: rd_mux[3:0] = pu_reg[addr_reg[6:4]];
				OFS_MODE: rd_mux[3:0] = mode_reg[addr_reg[6:4]];
				default: rd_mux = 32'h00000000;
			endcase
		end else begin
			case (addr_reg)
				ADDR_P45_DATA: rd_mux[7:0] = {pin_s[5], pin_s[4]};
				ADDR_IRQ_STATUS: rd_mux[NIRQ-1:0] = status_reg;
				ADDR_IRQ_ENABLE: rd_mux[NIRQ-1:0] = irq_en_reg;
				ADDR_CONFIG: rd_mux[1:0] = cfg_reg;
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_pullup_drive_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(p0_pu & ~p0_oe_n) == 3'h0 && (p6_pu & ~p6_oe_n) == 4'h0)
		else $error("pull-up on while pin drives");
	a_group_pullup: assert property (@(posedge hclk) disable iff (!hresetn)
		(pu_reg[4][0] && dir_reg[4] == 4'h0) |=> p4_pu == 4'hF)
		else $error("port 4 group pull-up wrong");
	a_od_release: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode_reg[4][0] && dir_reg[4][0] && dat_reg[4][0]) |=> p4_oe_n[0])
		else $error("open-drain pin drove a high");
	a_both_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_s[1][0] != $past(pin_s[1][0])) |=> status_reg[IRQ_EXT_BOTH])
		else $error("both-edge interrupt missed");
	a_sel_edge_wrong: assert property (@(posedge hclk) disable iff (!hresetn)
		(!status_reg[IRQ_EXT_SEL] && !cfg_reg[CFG_EDGE_FALL_BIT] && $fell(pin_s[1][1]))
		|=> !status_reg[IRQ_EXT_SEL])
		else $error("select-edge interrupt on wrong edge");
	a_sel_edge_hit: assert property (@(posedge hclk) disable iff (!hresetn)
		(cfg_reg[CFG_EDGE_FALL_BIT] && $fell(pin_s[1][1])) |=> status_reg[IRQ_EXT_SEL])
		else $error("select-edge falling interrupt missed");
	a_quasi_fall: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(pin_s[6][2]) |=> status_reg[IRQ_QUASI_LSB+2])
		else $error("quasi interrupt missed");
	a_cmp_three_ch: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg_reg[CFG_CMP_EXTREF_BIT] |=> (cmp_channel_en == CMP_THREE_CH && cmp_ext_ref_sel))
		else $error("external reference mode not three channels");
	a_inputs_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		(dir_reg[0] == 4'h0 && mode_reg[0] == 4'h0) |=> p0_oe_n == 3'h7)
		else $error("port 0 drives without enable");
	a_alt_owns_pin: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode_reg[6][3] && alt_p6_dir[3]) |=> (!p6_oe_n[3] && p6_out[3] == $past(alt_p6_out[3])))
		else $error("shared function lost the pin");
	a_bit_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(bitop_wr && bitop_port == 3'h3 && bitop_pin == 2'h1)
		|=> dat_reg[3][1] == $past(hwdata[BITOP_VAL_BIT]))
		else $error("bit write to port 3 lost");
	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(bus_reg == BUS_IDLE && acc && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

endmodule
`default_nettype wire

// >>> tb/mpgsp_pad.sv
// Board-side model of one port: pads with external drivers, pull-ups and floating pins
`timescale 1ns/1ps
`default_nettype none
module mpgsp_pad #(
	parameter int W = 4
) (
	input wire logic hclk,
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] oe_n,
	input wire logic [W-1:0] pu,
	input wire logic [W-1:0] ext_val,
	input wire logic [W-1:0] ext_en,
	output logic [W-1:0] pin
);
	logic flt = 1'b0;

	// A pin nobody holds must not look stable, so its level flips every cycle
	always @(posedge hclk) begin
		flt <= ~flt;
	end

	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (!oe_n[i]) begin
				pin[i] = out[i];
			end else if (ext_en[i]) begin
				pin[i] = ext_val[i];
			end else if (pu[i]) begin
				pin[i] = 1'b1;
			end else begin
				pin[i] = flt;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the seven-port GPIO block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mpgsp_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic hready, hreadyout, hresp, irq, cmp_ext_ref_sel;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ien = 32'h0;
	logic [1:0] htrans = 2'h0, p1_in, p1_pu;
	logic [2:0] hsize = 3'h2, p0_in, p0_out, p0_oe_n, p0_pu, p3_in, p3_out, p3_oe_n, p3_pu;
	logic [2:0] alt_p0_out = 3'h0, alt_p0_dir = 3'h0, alt_p3_out = 3'h0, alt_p3_dir = 3'h0;
	logic [3:0] p2_in, p4_in, p4_out, p4_oe_n, p4_pu, p5_in, p5_out, p5_oe_n, p5_pu;
	logic [3:0] p6_in, p6_out, p6_oe_n, p6_pu, cmp_channel_en;
	logic [3:0] alt_p6_out = 4'h0, alt_p6_dir = 4'h0;
	logic [3:0] ext_v [7] = '{default: 4'h0};
	logic [3:0] ext_e [7] = '{default: 4'hF};
	logic [3:0] idle_lo = 4'h0;
	logic [3:0] idle_hi = 4'hF;
	logic [3:0] o_out [7];
	logic [3:0] o_oen [7];
	logic [3:0] o_pu [7];
	int plist [5] = '{0, 3, 4, 5, 6};
	int err_total = 0, n_tests = 0;

	always #20 hclk = ~hclk;
	assign hready = hreadyout;
	assign o_out = '{{1'b0, p0_out}, 4'h0, 4'h0, {1'b0, p3_out}, p4_out, p5_out, p6_out};
	assign o_oen = '{{1'b1, p0_oe_n}, 4'hF, 4'hF, {1'b1, p3_oe_n}, p4_oe_n, p5_oe_n, p6_oe_n};
	assign o_pu = '{{1'b0, p0_pu}, {2'h0, p1_pu}, 4'h0, {1'b0, p3_pu}, p4_pu, p5_pu, p6_pu};

	mpgsp_top i_mpgsp_top (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
		.hresp, .hrdata, .p0_in, .p0_out, .p0_oe_n, .p0_pu, .p1_in, .p1_pu, .p2_in, .p3_in,
		.p3_out, .p3_oe_n, .p3_pu, .p4_in, .p4_out, .p4_oe_n, .p4_pu, .p5_in, .p5_out, .p5_oe_n,
		.p5_pu, .p6_in, .p6_out, .p6_oe_n, .p6_pu, .alt_p0_out, .alt_p0_dir, .alt_p3_out,
		.alt_p3_dir, .alt_p6_out, .alt_p6_dir, .cmp_channel_en, .cmp_ext_ref_sel, .irq
	);
	mpgsp_pad #(.W(3)) i_mpgsp_pad_p0 (.hclk, .out(p0_out), .oe_n(p0_oe_n), .pu(p0_pu),
		.ext_val(ext_v[0][2:0]), .ext_en(ext_e[0][2:0]), .pin(p0_in));
	mpgsp_pad #(.W(2)) i_mpgsp_pad_p1 (.hclk, .out(idle_lo[1:0]), .oe_n(idle_hi[1:0]),
		.pu(p1_pu), .ext_val(ext_v[1][1:0]), .ext_en(ext_e[1][1:0]), .pin(p1_in));
	mpgsp_pad #(.W(4)) i_mpgsp_pad_p2 (.hclk, .out(idle_lo), .oe_n(idle_hi), .pu(idle_lo),
		.ext_val(ext_v[2]), .ext_en(ext_e[2]), .pin(p2_in));
	mpgsp_pad #(.W(3)) i_mpgsp_pad_p3 (.hclk, .out(p3_out), .oe_n(p3_oe_n), .pu(p3_pu),
		.ext_val(ext_v[3][2:0]), .ext_en(ext_e[3][2:0]), .pin(p3_in));
	mpgsp_pad #(.W(4)) i_mpgsp_pad_p4 (.hclk, .out(p4_out), .oe_n(p4_oe_n), .pu(p4_pu),
		.ext_val(ext_v[4]), .ext_en(ext_e[4]), .pin(p4_in));
	mpgsp_pad #(.W(4)) i_mpgsp_pad_p5 (.hclk, .out(p5_out), .oe_n(p5_oe_n), .pu(p5_pu),
		.ext_val(ext_v[5]), .ext_en(ext_e[5]), .pin(p5_in));
	mpgsp_pad #(.W(4)) i_mpgsp_pad_p6 (.hclk, .out(p6_out), .oe_n(p6_oe_n), .pu(p6_pu),
		.ext_val(ext_v[6]), .ext_en(ext_e[6]), .pin(p6_in));

	// ---------------------------------------------------------------
	// Checking and bus tasks
	// ---------------------------------------------------------------
	task automatic test_done();
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bounded waits on hready; a stuck slave ends the run as a failure
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 64);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 64);
		r = hrdata;
		if (k >= 64) begin
			err_total++;
			test_done();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask

	function automatic logic [3:0] exp_pu(input int p, input logic [3:0] pu, input logic [3:0] dir);
		logic [3:0] g;
		g = (p == 4 || p == 5) ? {4{pu[0]}} : pu;
		return g & ~dir;
	endfunction

	// Pin change, then status and irq against the enabled set, then clear all
	task automatic evt(input int p, input logic [3:0] v, input logic [31:0] e);
		ext_v[p] <= v;
		repeat (8) @(posedge hclk);
		rd(ADDR_IRQ_STATUS, e);
		chk(32'(irq), 32'(|(e & ien)));
		wr(ADDR_IRQ_CLEAR, 32'h1F);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [3:0] m, dir, dat, pu, ev;
		logic [7:0] b;
		int p;
		void'($urandom(32'h958D));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(32'({p0_oe_n, p3_oe_n, p4_oe_n, p5_oe_n, p6_oe_n}), 32'h3FFFF);
		chk(32'({p0_pu, p1_pu, p3_pu, p4_pu, p5_pu, p6_pu, irq, hresp}), 32'h0);
		chk(32'(cmp_channel_en), 32'(CMP_ALL_CH));
		for (int it = 0; it < 6; it++) begin
			foreach (plist[j]) begin
				p = plist[j];
				m = WIDTH_MASK[p];
				dir = (it == 0) ? m : (it == 1) ? 4'h0 : 4'($urandom) & m;
				dat = 4'($urandom);
				pu = (it == 1) ? 4'hF : 4'($urandom);
				ev = 4'($urandom);
				ext_v[p] <= ev;
				wr(8'(p * 16) + OFS_DIR, 32'(dir));
				wr(8'(p * 16) + OFS_DATA, 32'(dat & m));
				wr(8'(p * 16) + OFS_PULLUP, 32'(pu & m));
				repeat (3) @(posedge hclk);
				chk(32'(o_oen[p] & m), 32'(~dir & m));
				chk(32'(o_out[p] & dir), 32'(dat & dir));
				chk(32'(o_pu[p] & m), 32'(exp_pu(p, pu, dir) & m));
				rd(8'(p * 16) + OFS_DATA, 32'((dir & dat | ~dir & ev) & m));
				rd(8'(p * 16) + OFS_DIR, 32'(dir));
			end
		end
		ext_v[1] <= 4'($urandom);
		ext_v[2] <= 4'($urandom);
		wr(8'h18, 32'h3);
		repeat (4) @(posedge hclk);
		chk(32'(p1_pu), 32'h3);
		rd(8'h10, 32'(ext_v[1] & 4'h3));
		rd(8'h20, 32'(ext_v[2]));
		rd(8'h14, 32'h0);
		// Released pins must read high through the pull-ups
		ext_e[1] <= 4'h0;
		repeat (4) @(posedge hclk);
		rd(8'h10, 32'h3);
		ext_e[1] <= 4'hF;
		b = 8'($urandom);
		wr(8'h44, 32'hF);
		wr(8'h54, 32'hF);
		wr(ADDR_P45_DATA, 32'(b));
		repeat (3) @(posedge hclk);
		chk(32'({p5_out, p4_out}), 32'(b));
		rd(ADDR_P45_DATA, 32'(b));
		wr(8'h4C, 32'hF);
		repeat (3) @(posedge hclk);
		chk(32'(p4_oe_n), 32'(b[3:0]));
		chk(32'(p4_pu), 32'h0);
		wr(8'h4C, 32'h0);
		wr(8'h04, 32'h7);
		wr(8'h00, 32'h0);
		wr(ADDR_BITOP, 32'h102);
		repeat (3) @(posedge hclk);
		chk(32'(p0_out), 32'h4);
		wr(ADDR_BITOP, 32'h131);
		repeat (3) @(posedge hclk);
		chk(32'(p3_out[1]), 32'h1);
		alt_p0_out <= 3'($urandom);
		alt_p0_dir <= 3'($urandom);
		alt_p3_out <= 3'($urandom);
		alt_p3_dir <= 3'($urandom);
		alt_p6_out <= 4'($urandom);
		alt_p6_dir <= 4'($urandom);
		wr(8'h0C, 32'h7);
		wr(8'h6C, 32'hF);
		repeat (3) @(posedge hclk);
		chk(32'(p6_oe_n ^ alt_p6_dir), 32'hF);
		chk(32'(p6_out & alt_p6_dir), 32'(alt_p6_out & alt_p6_dir));
		chk(32'(p0_oe_n ^ alt_p0_dir), 32'h7);
		wr(8'h0C, 32'h0);
		wr(8'h6C, 32'h0);
		wr(ADDR_CONFIG, 32'h2);
		repeat (3) @(posedge hclk);
		chk(32'({cmp_ext_ref_sel, cmp_channel_en}), 32'h17);
		wr(ADDR_CONFIG, 32'h0);
		repeat (3) @(posedge hclk);
		chk(32'({cmp_ext_ref_sel, cmp_channel_en}), 32'h0F);
		wr(8'h64, 32'h0);
		ext_v[1] <= 4'h0;
		ext_v[6] <= 4'h0;
		repeat (8) @(posedge hclk);
		wr(ADDR_IRQ_CLEAR, 32'h1F);
		ien = 32'h1F;
		wr(ADDR_IRQ_ENABLE, ien);
		rd(ADDR_IRQ_ENABLE, ien);
		evt(1, 4'h1, 32'h01);
		evt(1, 4'h0, 32'h01);
		evt(1, 4'h2, 32'h02);
		evt(1, 4'h0, 32'h00);
		wr(ADDR_CONFIG, 32'h1);
		evt(1, 4'h2, 32'h00);
		evt(1, 4'h0, 32'h02);
		ien = 32'h04;
		wr(ADDR_IRQ_ENABLE, ien);
		evt(6, 4'h7, 32'h00);
		evt(6, 4'h3, 32'h10);
		evt(6, 4'h0, 32'h0C);
		wr(8'h90, 32'hFFFFFFFF);
		rd(8'h90, 32'h0);
		test_done();
	end
endmodule
`default_nettype wire
